/* File: src/sector_lock_pkg.sv */
// package: register map, field positions, reset values and carriers of the
// sector lock and configuration block.
// assumes a serial-protocol engine presents decoded byte accesses.
package sector_lock_pkg;

    // byte address width of the serial side
    localparam int ADDR_W = 13;
    localparam int SECTORS = 64;
    // log2 of the sector size in bytes (8192 bytes over 64 sectors)
    localparam int SECTOR_SHIFT = 7;

    // system-area byte addresses, valid with system_area_select at 1
    localparam logic [12:0] GUARD_LOW_ADDR = 13'h0800;
    localparam logic [12:0] GUARD_HIGH_ADDR = 13'h0804;
    localparam logic [12:0] CONFIG_ADDR = 13'h0910;
    localparam logic [12:0] CONTROL_ADDR = 13'h0920;
    localparam logic [12:0] GUARD_SPAN = 13'h0008;

    // reset values
    localparam logic [31:0] GUARD_RESET = 32'h0000_0000;
    localparam logic [7:0] CONFIG_DELIVERY = 8'hF4;

    // configuration byte fields
    localparam int CFG_SINK_LSB = 0;
    localparam int CFG_SINK_MSB = 1;
    localparam int CFG_HARVEST_OFF = 2;
    localparam int CFG_PIN_MODE = 3;

    // control byte fields
    localparam int CTL_HARVEST_ON = 0;
    localparam int CTL_FIELD_ON = 1;

    // activity pin modes
    localparam logic PIN_MODE_BUSY = 1'b0;
    localparam logic PIN_MODE_WIP = 1'b1;

    // decoded serial byte access
    typedef struct packed {
        logic system_area_select;
        logic we;
        logic [12:0] addr;
        logic [7:0] wdata;
    } sys_req_s;

    // radio command progress events, one-cycle pulses on the radio clock
    typedef struct packed {
        logic sof;
        logic crc_done;
        logic cmd_bad;
        logic exec_done;
        logic write_end;
        logic answer_start;
    } rf_evt_s;

endpackage

/* File: src/sector_lock_and_config.sv */
// holds the serial-side sector write guards, configuration and control bytes,
// drives the open-drain activity pin and gates the harvesting output.
// assumes a serial engine on core_clk and a radio front end on rf_clk.
//
// What this block does
// - guard area: 8 bytes, system area only
// - one guard bit per sector, two words
// - guard bit 1 blocks serial writes
// - guard reads free, writes need password
// - guard bits cleared only with password
// - guard bytes reset to zero
// - presented rights only for linked sectors
// - configuration byte at 2320
// - control byte at 2336
// - config bit 3 picks pin mode
// - activity pin pulls low or floats
// - busy: low from SOF to execution end
// - bad command: low until CRC only
// - field loss releases pin at once
// - busy mode: serial commands never pull
// - write mode: low from write end to answer
// - write mode: serial writes never pull
// - harvest out needs enable and power
// - config bits: sink level, default, pin mode, don't care
// - enable loads as inverse of default bit
// - control bit 0 writable, rest read-only
// - control bit 1 shows field present
`timescale 1ns/100ps

module sector_lock_and_config #(
    parameter logic [7:0] CONFIG_INIT = sector_lock_pkg::CONFIG_DELIVERY
) (
    input wire logic core_clk,
    input wire logic arst_n,
    // serial system-area access port
    input wire logic sys_req,
    input wire sector_lock_pkg::sys_req_s sys_cmd,
    output logic sys_ack,
    output logic sys_err,
    output logic [7:0] sys_rdata,
    // serial password state, same clock
    input wire logic serial_pwd_ok,
    // serial user-write check
    input wire logic [12:0] user_wr_addr,
    output logic user_wr_blocked,
    // analog level: received power sufficient for harvesting
    input wire logic power_ok,
    output logic harvest_output_on,
    output logic [1:0] sink_level,
    // radio side, own clock
    input wire logic rf_clk,
    input wire logic field_present,
    input wire sector_lock_pkg::rf_evt_s rf_evt,
    input wire logic rf_pwd_ok,
    input wire logic rf_pwd_fail,
    input wire logic [1:0] rf_pwd_idx,
    input wire logic [1:0] rf_sector_link,
    output logic rf_use_presented,
    // open-drain activity pin
    input wire logic radio_activity_pin_i,
    output logic radio_activity_pin_o,
    output logic radio_activity_pin_oe
);

    // activity pin holders
    typedef enum logic [1:0] {
        PIN_IDLE,
        PIN_BUSY,
        PIN_WIP
    } pin_state_e;

    logic rst_meta_r;
    logic rst_n_r;
    logic rf_rst_meta_r;
    logic rf_rst_n_r;
    logic [31:0] guard_low_r;
    logic [31:0] guard_high_r;
    logic [7:0] config_r;
    logic harvest_on_r;
    logic field_meta_r;
    logic field_sync_r;
    logic power_meta_r;
    logic power_sync_r;
    logic mode_meta_r;
    logic mode_sync_r;
    logic [1:0] presented_r;
    pin_state_e pin_state_r;
    pin_state_e pin_state_nxt;
    logic hit_guard;
    logic hit_config;
    logic hit_control;
    logic [2:0] guard_byte;
    logic [63:0] guard_all;
    logic [5:0] wr_sector;
    logic wr_guard;
    logic wr_config;
    logic wr_control;
    logic rd_req;
    logic unmapped;
    logic refused;
    logic [7:0] control_rd;
    logic pin_hold;

    // guard byte index inside the 8-byte area
    function automatic logic [2:0] guard_index(input logic [12:0] addr);
        logic [12:0] off;
        off = addr - sector_lock_pkg::GUARD_LOW_ADDR;
        return off[2:0];
    endfunction

    // true when the address falls inside the guard area
    function automatic logic in_guard(input logic [12:0] addr);
        return addr >= sector_lock_pkg::GUARD_LOW_ADDR &&
               addr < sector_lock_pkg::GUARD_LOW_ADDR + sector_lock_pkg::GUARD_SPAN;
    endfunction

    // true for a system-area access to one given byte
    function automatic logic sys_hit(input sector_lock_pkg::sys_req_s cmd, input logic [12:0] target);
        return cmd.system_area_select && cmd.addr == target;
    endfunction

    // core reset release through two flops
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end

    // radio reset release through two flops
    always_ff @(posedge rf_clk or negedge arst_n) begin
        if (!arst_n) begin
            rf_rst_meta_r <= 1'b0;
            rf_rst_n_r <= 1'b0;
        end else begin
            rf_rst_meta_r <= 1'b1;
            rf_rst_n_r <= rf_rst_meta_r;
        end
    end

    // field and power levels into the core domain
    always_ff @(posedge core_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            field_meta_r <= 1'b0;
            field_sync_r <= 1'b0;
            power_meta_r <= 1'b0;
            power_sync_r <= 1'b0;
        end else begin
            field_meta_r <= field_present;
            field_sync_r <= field_meta_r;
            power_meta_r <= power_ok;
            power_sync_r <= power_meta_r;
        end
    end

    // address decode, only with system_area_select set
    assign hit_guard = sys_cmd.system_area_select && in_guard(sys_cmd.addr);
    assign hit_config = sys_hit(sys_cmd, sector_lock_pkg::CONFIG_ADDR);
    assign hit_control = sys_hit(sys_cmd, sector_lock_pkg::CONTROL_ADDR);
    assign guard_byte = guard_index(sys_cmd.addr);
    assign guard_all = {guard_high_r, guard_low_r};

    // qualified strobes; a refused guard write leaves the guards untouched
    assign wr_guard = sys_req && sys_cmd.we && hit_guard && serial_pwd_ok;
    assign wr_config = sys_req && sys_cmd.we && hit_config;
    assign wr_control = sys_req && sys_cmd.we && hit_control;
    assign rd_req = sys_req && !sys_cmd.we;
    assign unmapped = !hit_guard && !hit_config && !hit_control;
    assign refused = sys_cmd.we && hit_guard && !serial_pwd_ok;

    // guard words, written bytewise after the serial password
    always_ff @(posedge core_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            guard_low_r <= sector_lock_pkg::GUARD_RESET;
            guard_high_r <= sector_lock_pkg::GUARD_RESET;
        end else if (wr_guard) begin
            if (guard_byte[2]) begin
                guard_high_r[guard_byte[1:0]*8 +: 8] <= sys_cmd.wdata;
            end else begin
                guard_low_r[guard_byte[1:0]*8 +: 8] <= sys_cmd.wdata;
            end
        end
    end

    // configuration byte, all bits stored
    // bits 7 to 4 are kept for read-back but drive nothing
    always_ff @(posedge core_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            config_r <= CONFIG_INIT;
        end else if (wr_config) begin
            config_r <= sys_cmd.wdata;
        end
    end

    // harvesting enable, power-up value from the default bit
    // only bit 0 is writable; writes to the other bits are dropped
    always_ff @(posedge core_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            harvest_on_r <= ~CONFIG_INIT[sector_lock_pkg::CFG_HARVEST_OFF];
        end else if (wr_control) begin
            harvest_on_r <= sys_cmd.wdata[sector_lock_pkg::CTL_HARVEST_ON];
        end
    end

    // access answer: ack every request, flag unmapped or refused
    always_ff @(posedge core_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            sys_ack <= 1'b0;
            sys_err <= 1'b0;
        end else begin
            sys_ack <= sys_req;
            sys_err <= sys_req && (unmapped || refused);
        end
    end

    // control byte image, bits 7 to 2 at zero
    always_comb begin
        control_rd = 8'h00;
        control_rd[sector_lock_pkg::CTL_HARVEST_ON] = harvest_on_r;
        control_rd[sector_lock_pkg::CTL_FIELD_ON] = field_sync_r;
    end

    // read data, guard reads never refused
    always_ff @(posedge core_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            sys_rdata <= 8'h00;
        end else if (rd_req) begin
            if (hit_guard) begin
                sys_rdata <= guard_all[guard_byte*8 +: 8];
            end else if (hit_config) begin
                sys_rdata <= config_r;
            end else if (hit_control) begin
                sys_rdata <= control_rd;
            end else begin
                sys_rdata <= 8'h00;
            end
        end
    end

    // serial user-write check by sector guard bit
    assign wr_sector = user_wr_addr[sector_lock_pkg::SECTOR_SHIFT +: 6];

    // one cycle late; the serial engine asks before it commits a write
    always_ff @(posedge core_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            user_wr_blocked <= 1'b0;
        end else begin
            user_wr_blocked <= guard_all[wr_sector];
        end
    end

    // harvesting output and sink level
    // power is seen three cycles late through synchroniser and output flop
    always_ff @(posedge core_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            harvest_output_on <= 1'b0;
            sink_level <= 2'b00;
        end else begin
            harvest_output_on <= harvest_on_r && power_sync_r;
            sink_level <= config_r[sector_lock_pkg::CFG_SINK_MSB:sector_lock_pkg::CFG_SINK_LSB];
        end
    end

    // pin mode bit into the radio domain
    // a mode change in mid-frame is seen two radio edges later
    always_ff @(posedge rf_clk or negedge rf_rst_n_r) begin
        if (!rf_rst_n_r) begin
            mode_meta_r <= sector_lock_pkg::PIN_MODE_BUSY;
            mode_sync_r <= sector_lock_pkg::PIN_MODE_BUSY;
        end else begin
            mode_meta_r <= config_r[sector_lock_pkg::CFG_PIN_MODE];
            mode_sync_r <= mode_meta_r;
        end
    end

    // presented radio password, cleared by a failed attempt
    // code 0 stands for none presented, so unlinked sectors never match
    always_ff @(posedge rf_clk or negedge rf_rst_n_r) begin
        if (!rf_rst_n_r) begin
            presented_r <= 2'b00;
        end else if (rf_pwd_ok) begin
            presented_r <= rf_pwd_idx;
        end else if (rf_pwd_fail) begin
            presented_r <= 2'b00;
        end
    end

    // rights for the queried sector: presented only when linked
    always_ff @(posedge rf_clk or negedge rf_rst_n_r) begin
        if (!rf_rst_n_r) begin
            rf_use_presented <= 1'b0;
        end else begin
            rf_use_presented <= rf_sector_link != 2'b00 && rf_sector_link == presented_r;
        end
    end

    // activity pin sequencing, driven by radio events only
    always_comb begin
        pin_state_nxt = pin_state_r;
        case (pin_state_r)
            PIN_IDLE: begin
                if (mode_sync_r == sector_lock_pkg::PIN_MODE_BUSY && rf_evt.sof) begin
                    pin_state_nxt = PIN_BUSY;
                end else if (mode_sync_r == sector_lock_pkg::PIN_MODE_WIP && rf_evt.write_end) begin
                    pin_state_nxt = PIN_WIP;
                end
            end
            // a bad frame ends at its crc, a good one at execution end
            PIN_BUSY: begin
                if (rf_evt.crc_done && rf_evt.cmd_bad) begin
                    pin_state_nxt = PIN_IDLE;
                end else if (rf_evt.exec_done) begin
                    pin_state_nxt = PIN_IDLE;
                end
            end
            PIN_WIP: begin
                if (rf_evt.answer_start) begin
                    pin_state_nxt = PIN_IDLE;
                end
            end
            default: begin
                pin_state_nxt = PIN_IDLE;
            end
        endcase
        if (!field_present) begin
            pin_state_nxt = PIN_IDLE;
        end
    end

    // pin state register; events are one-cycle radio pulses
    always_ff @(posedge rf_clk or negedge rf_rst_n_r) begin
        if (!rf_rst_n_r) begin
            pin_state_r <= PIN_IDLE;
        end else begin
            pin_state_r <= pin_state_nxt;
        end
    end

    // pin holder flag; serial traffic has no path into it
    assign pin_hold = pin_state_r != PIN_IDLE;

    // open drain: output low, enable while holding; field gate is immediate
    // the field gate has no flop so the pin lets go without waiting for rf_clk
    assign radio_activity_pin_o = 1'b0;
    assign radio_activity_pin_oe = pin_hold && field_present;

endmodule

/* File: verif/sector_lock_monitor.sv */
// checker: access answers, activity pin and harvest gating.
// assumes bind onto sector_lock_and_config; both domains use arst_n.
`timescale 1ns/100ps
module sector_lock_monitor (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic sys_req,
    input wire sector_lock_pkg::sys_req_s sys_cmd,
    input wire logic sys_ack,
    input wire logic sys_err,
    input wire logic serial_pwd_ok,
    input wire logic power_ok,
    input wire logic harvest_output_on,
    input wire logic rf_clk,
    input wire logic field_present,
    input wire sector_lock_pkg::rf_evt_s rf_evt,
    input wire logic radio_activity_pin_o,
    input wire logic radio_activity_pin_oe
);
    // guard byte access, pin start and end causes
    logic guard_hit, start_evt, end_evt;
    assign guard_hit = sys_req && sys_cmd.system_area_select && sys_cmd.addr[12:3] == 10'h100;
    assign start_evt = rf_evt.sof || rf_evt.write_end;
    assign end_evt = rf_evt.exec_done || (rf_evt.crc_done && rf_evt.cmd_bad) || rf_evt.answer_start || !field_present;

    property p_ack;
        @(posedge core_clk) disable iff (!arst_n) sys_req |=> sys_ack;
    endproperty
    a_ack: assert property (p_ack) else $error("access not answered");
    property p_sel;
        @(posedge core_clk) disable iff (!arst_n) sys_req && !sys_cmd.system_area_select |=> sys_err;
    endproperty
    a_sel: assert property (p_sel) else $error("unselected access accepted");
    property p_nopwd;
        @(posedge core_clk) disable iff (!arst_n) guard_hit && sys_cmd.we && !serial_pwd_ok |=> sys_err;
    endproperty
    a_nopwd: assert property (p_nopwd) else $error("guard write without password");
    property p_rd;
        @(posedge core_clk) disable iff (!arst_n) guard_hit && !sys_cmd.we |=> !sys_err;
    endproperty
    a_rd: assert property (p_rd) else $error("guard read refused");
    property p_drive;
        @(posedge rf_clk) disable iff (!arst_n) !radio_activity_pin_o;
    endproperty
    a_drive: assert property (p_drive) else $error("pin driven high");
    property p_field;
        @(posedge rf_clk) disable iff (!arst_n) !field_present |-> !radio_activity_pin_oe;
    endproperty
    a_field: assert property (p_field) else $error("pin held without field");
    property p_rise;
        @(posedge rf_clk) disable iff (!arst_n) $rose(radio_activity_pin_oe) |-> $past(start_evt);
    endproperty
    a_rise: assert property (p_rise) else $error("pin pulled without cause");
    property p_fall;
        @(posedge rf_clk) disable iff (!arst_n) $fell(radio_activity_pin_oe) |-> $past(end_evt) || !field_present;
    endproperty
    a_fall: assert property (p_fall) else $error("pin released early");
    property p_harvest;
        @(posedge core_clk) disable iff (!arst_n) harvest_output_on |-> $past(power_ok, 3);
    endproperty
    a_harvest: assert property (p_harvest) else $error("harvest on without power");
endmodule

bind sector_lock_and_config sector_lock_monitor u_monitor (
    .core_clk, .arst_n, .sys_req, .sys_cmd, .sys_ack, .sys_err, .serial_pwd_ok, .power_ok,
    .harvest_output_on, .rf_clk, .field_present, .rf_evt, .radio_activity_pin_o, .radio_activity_pin_oe
);

/* File: verif/radio_front_model.sv */
// radio front end model: command progress pulses and password results.
// assumes the bench calls its tasks; outputs move 1 ns after rf_clk rises.
`timescale 1ns/100ps
module radio_front_model (
    input wire logic rf_clk,
    output sector_lock_pkg::rf_evt_s rf_evt,
    output logic rf_pwd_ok,
    output logic rf_pwd_fail,
    output logic [1:0] rf_pwd_idx
);
    initial begin
        rf_evt = '0;
        rf_pwd_ok = 1'b0;
        rf_pwd_fail = 1'b0;
        rf_pwd_idx = 2'h0;
    end
    // one-cycle pulse of a set of events
    task pulse(input logic [5:0] e);
        @(posedge rf_clk);
        #1 rf_evt = e;
        @(posedge rf_clk);
        #1 rf_evt = '0;
    endtask
    // kind 0 good, 1 bad, 2 write: sof or write end opens
    task open_frame(input int kind);
        pulse(kind == 2 ? 6'h02 : 6'h20);
    endtask
    // matching close comes only after the opening
    task close_frame(input int kind);
        pulse(kind == 0 ? 6'h04 : (kind == 1 ? 6'h18 : 6'h01));
    endtask
    // password result; index lines flip once released
    task present(input logic ok, input logic [1:0] idx);
        @(posedge rf_clk);
        #1 rf_pwd_ok = ok;
        rf_pwd_fail = !ok;
        rf_pwd_idx = idx;
        @(posedge rf_clk);
        #1 rf_pwd_ok = 1'b0;
        rf_pwd_fail = 1'b0;
        rf_pwd_idx = ~idx;
    endtask
endmodule

/* File: verif/sector_lock_and_config_tb.sv */
// bench for sector_lock_and_config: byte accesses, guards, pin and rights.
// assumes the checker is bound in and the radio model drives rf events.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin fails++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
module sector_lock_and_config_tb;
    logic core_clk;
    logic rf_clk;
    logic arst_n;
    logic sys_req;
    sector_lock_pkg::sys_req_s sys_cmd;
    logic serial_pwd_ok;
    logic [12:0] user_wr_addr;
    logic power_ok;
    logic field_present;
    logic [1:0] rf_sector_link;
    logic sys_ack, sys_err, user_wr_blocked, harvest_output_on, rf_use_presented, er;
    logic rf_pwd_ok, rf_pwd_fail, radio_activity_pin_o, radio_activity_pin_oe;
    logic [7:0] sys_rdata, rd;
    logic [1:0] sink_level, rf_pwd_idx;
    sector_lock_pkg::rf_evt_s rf_evt;
    wire radio_activity_pin_i;
    int fails = 0;
    int check_count = 0;

    // pull-up on the open-drain pin
    assign radio_activity_pin_i = radio_activity_pin_oe ? radio_activity_pin_o : 1'b1;

    sector_lock_and_config dut (
        .core_clk, .arst_n, .sys_req, .sys_cmd, .sys_ack, .sys_err, .sys_rdata, .serial_pwd_ok,
        .user_wr_addr, .user_wr_blocked, .power_ok, .harvest_output_on, .sink_level, .rf_clk,
        .field_present, .rf_evt, .rf_pwd_ok, .rf_pwd_fail, .rf_pwd_idx, .rf_sector_link,
        .rf_use_presented, .radio_activity_pin_i, .radio_activity_pin_o, .radio_activity_pin_oe
    );
    radio_front_model rf (.rf_clk, .rf_evt, .rf_pwd_ok, .rf_pwd_fail, .rf_pwd_idx);

    // clocks and hang guard
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    initial begin
        rf_clk = 1'b0;
        #37;
        forever #80 rf_clk = ~rf_clk;
    end
    initial begin
        repeat (40000) @(posedge core_clk);
        fails++;
        final_report();
    end

    task cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task rcyc(input int n);
        repeat (n) @(posedge rf_clk);
        #1;
    endtask
    // one byte access, answer taken one cycle later
    task acc(input logic sel, input logic we, input logic [12:0] a, input logic [7:0] d);
        cyc(1);
        sys_req = 1'b1;
        sys_cmd = '{sel, we, a, d};
        cyc(1);
        sys_req = 1'b0;
        er = sys_err;
        rd = sys_rdata;
        `CHK("ack", 1'b1, sys_ack)
    endtask
    task rchk(input string nm, input logic [12:0] a, input logic [7:0] e);
        acc(1'b1, 1'b0, a, 8'h00);
        `CHK(nm, e, rd)
    endtask
    task blk(input logic [12:0] a, input logic e);
        user_wr_addr = a;
        cyc(1);
        `CHK("blocked", e, user_wr_blocked)
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    initial begin
        arst_n = 1'b0;
        sys_req = 1'b0;
        sys_cmd = '0;
        serial_pwd_ok = 1'b0;
        user_wr_addr = 13'h0000;
        power_ok = 1'b0;
        field_present = 1'b1;
        rf_sector_link = 2'h0;
        cyc(6);
        arst_n = 1'b1;
        rcyc(3);
        for (int k = 0; k < 8; k++) rchk("guard", 13'h0800 + 13'(k), 8'h00);
        rchk("config", 13'h0910, 8'hF4);
        rchk("control", 13'h0920, 8'h02);
        $display("test reset values done");
        acc(1'b1, 1'b1, 13'h0800, 8'h01);
        `CHK("no password", 1'b1, er)
        rchk("guard kept", 13'h0800, 8'h00);
        serial_pwd_ok = 1'b1;
        acc(1'b1, 1'b1, 13'h0800, 8'h01);
        acc(1'b1, 1'b1, 13'h0807, 8'h80);
        blk(13'h0000, 1'b1);
        blk(13'h0080, 1'b0);
        blk(13'h1F80, 1'b1);
        blk(13'h1000, 1'b0);
        acc(1'b1, 1'b1, 13'h0800, 8'h00);
        blk(13'h0000, 1'b0);
        acc(1'b0, 1'b0, 13'h0800, 8'h00);
        `CHK("select", 1'b1, er)
        acc(1'b1, 1'b0, 13'h0808, 8'h00);
        `CHK("unmapped", 1'b1, er)
        $display("test guards done");
        power_ok = 1'b1;
        cyc(4);
        `CHK("harvest off", 1'b0, harvest_output_on)
        acc(1'b1, 1'b1, 13'h0920, 8'hFF);
        rchk("control", 13'h0920, 8'h03);
        cyc(3);
        `CHK("harvest on", 1'b1, harvest_output_on)
        power_ok = 1'b0;
        cyc(4);
        `CHK("harvest lost", 1'b0, harvest_output_on)
        acc(1'b1, 1'b1, 13'h0910, 8'h02);
        rchk("config", 13'h0910, 8'h02);
        `CHK("sink", 2'h2, sink_level)
        $display("test harvest done");
        rcyc(3);
        rf.open_frame(0);
        `CHK("busy", 1'b0, radio_activity_pin_i)
        rf.pulse(6'h10);
        `CHK("busy crc", 1'b0, radio_activity_pin_i)
        rf.close_frame(0);
        `CHK("busy end", 1'b1, radio_activity_pin_i)
        rf.open_frame(1);
        `CHK("bad", 1'b0, radio_activity_pin_i)
        rf.close_frame(1);
        `CHK("bad end", 1'b1, radio_activity_pin_i)
        rf.open_frame(2);
        `CHK("write in busy", 1'b1, radio_activity_pin_i)
        rf.close_frame(2);
        acc(1'b1, 1'b1, 13'h0800, 8'h00);
        `CHK("serial", 1'b1, radio_activity_pin_i)
        rf.open_frame(0);
        field_present = 1'b0;
        #1 `CHK("field cut", 1'b1, radio_activity_pin_i)
        cyc(4);
        rchk("no field", 13'h0920, 8'h01);
        rcyc(2);
        field_present = 1'b1;
        rcyc(1);
        `CHK("field back", 1'b1, radio_activity_pin_i)
        rf.close_frame(0);
        $display("test busy mode done");
        acc(1'b1, 1'b1, 13'h0910, 8'h0B);
        rcyc(3);
        `CHK("sink wip", 2'h3, sink_level)
        rf.open_frame(0);
        `CHK("busy in write", 1'b1, radio_activity_pin_i)
        rf.close_frame(0);
        rf.open_frame(2);
        `CHK("write", 1'b0, radio_activity_pin_i)
        rf.close_frame(2);
        `CHK("answer", 1'b1, radio_activity_pin_i)
        acc(1'b1, 1'b1, 13'h0800, 8'h00);
        `CHK("serial write", 1'b1, radio_activity_pin_i)
        $display("test write mode done");
        rf.present(1'b1, 2'h1);
        for (int k = 0; k < 4; k++) begin
            rf_sector_link = 2'(k);
            rcyc(2);
            `CHK("rights", k == 1, rf_use_presented)
        end
        rf_sector_link = 2'h1;
        rf.present(1'b0, 2'h1);
        rcyc(2);
        `CHK("rights cleared", 1'b0, rf_use_presented)
        $display("test rights done");
        final_report();
    end
endmodule
